/* shared/dtdu_cfg.svh */
// Constants for the acquisition timing and output update block
// What this block does
// [RL1] Two output channels, each a 12-bit code loaded by low and high byte writes.
// [RL2] With deferred update clear, a channel code reaches its output on its write.
// [RL3] With deferred update set, outputs change only on counter 2 or external update falls.
// [RL4] Bipolar code 800 gives the lowest level; unipolar code zero gives zero volts.
// [RL5] Each group holds three 16-bit counters and one 8-bit mode register.
// [RL6] Group A paces acquisition; group B is left for host general timing.
// [RL7] Group A runs from 1 MHz derived from 10 MHz, or from general counter 0.
// [RL8] General counter 0 runs from a 2 MHz timebase.
// [RL9] General counter 0 as group A clock gives periods beyond 65,536 us.
// [RL10] In interval scanning, general counter 1 shares the acquisition counter 0 clock.
// [RL11] In interval scanning, each general counter 1 pulse starts one scan sequence; the code ignores pulses while acquisition is idle.
// [RL12] The far side supplies clocks for general counters 1 and 2 on the connector.
// [RL13] Single-channel interval mode counts samples, pauses until next interval start, repeats.
// [RL14] In controlled mode, acquisition ends when the sample counter has counted down to zero.
// [RL15] Each counter has its own clock, gate and output, numbered 0 to 2.
// [RL16] Sample interval counter pulses at zero, reloads and repeats until reprogrammed.
// [RL17] In controlled mode the sample counter gates off counter 0 when expired.
// [RL18] External update is synchronised before falling-edge detection; counter 2 output is not.
`ifndef DTDU_CFG_SVH
`define DTDU_CFG_SVH

// Host write port targets
`define DTDU_ADDR_ACQ0 4'h0
`define DTDU_ADDR_ACQ1 4'h1
`define DTDU_ADDR_ACQ2 4'h2
`define DTDU_ADDR_GEN0 4'h3
`define DTDU_ADDR_GEN1 4'h4
`define DTDU_ADDR_GEN2 4'h5
`define DTDU_ADDR_MODE_A 4'h6
`define DTDU_ADDR_MODE_B 4'h7
`define DTDU_ADDR_DAC0_LO 4'h8
`define DTDU_ADDR_DAC0_HI 4'h9
`define DTDU_ADDR_DAC1_LO 4'hA
`define DTDU_ADDR_DAC1_HI 4'hB
`define DTDU_ADDR_INTERVAL 4'hC

// Reset values
`define DTDU_MODE_A_RST 8'h05
`define DTDU_MODE_B_RST 8'h00
`define DTDU_INTERVAL_RST 8'h01
`define DTDU_CODE_RST 12'h000

// Code fields
`define DTDU_BIPOLAR_FLIP 12'h800
`define DTDU_HI_NIBBLE_W 4

// Timing
`define DTDU_CLK_PERIOD_NS 10
`define DTDU_OSC_PERIOD_NS 100
`define DTDU_TBA_PERIOD_NS 1000
`define DTDU_TBB0_PERIOD_NS 500
`define DTDU_OSC_DIV (`DTDU_OSC_PERIOD_NS / `DTDU_CLK_PERIOD_NS)
`define DTDU_TBA_DIV (`DTDU_TBA_PERIOD_NS / `DTDU_OSC_PERIOD_NS)
`define DTDU_TBB0_DIV (`DTDU_TBB0_PERIOD_NS / `DTDU_CLK_PERIOD_NS)

`endif

/* shared/dtdu_pkg.sv */
// Types for the acquisition timing and output update block
package dtdu_pkg;
	typedef logic [15:0] dtdu_count_t;
	typedef logic [11:0] dtdu_code_t;
	typedef logic [7:0] dtdu_byte_t;
	typedef logic [3:0] dtdu_addr_t;
	typedef enum logic [2:0] {
		DTDU_IDLE = 3'b001,
		DTDU_RUN = 3'b010,
		DTDU_PAUSE = 3'b100
	} dtdu_acq_e;
endpackage

/* rtl/dtdu_counter.sv */
// One 16-bit down counter with clock tick, gate and output
`timescale 1ns/1ns
`default_nettype none
module dtdu_counter (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Counter clock, gate and mode
	input wire logic tick,
	input wire logic gate,
	input wire logic repeat_mode,
	// Load
	input wire logic load,
	input wire dtdu_pkg::dtdu_count_t load_value,
	// State
	output logic cnt_out,
	output logic expired
);
	import dtdu_pkg::*;

	dtdu_count_t count_reg;
	dtdu_count_t reload_reg;
	logic armed_reg;
	logic out_reg;

	wire count_now = tick && gate && armed_reg;
	wire at_one = (count_reg == 16'h0001);
	wire at_zero = (count_reg == 16'h0000);

	assign cnt_out = out_reg;
	assign expired = armed_reg && !repeat_mode && at_zero;

	always_ff @(posedge clk) begin
		if (srst) begin
			count_reg <= 16'h0000;
			reload_reg <= 16'h0000;
			armed_reg <= 1'b0;
			out_reg <= 1'b1;
		end else if (load) begin
			count_reg <= load_value;
			reload_reg <= load_value;
			armed_reg <= 1'b1;
			out_reg <= repeat_mode;
		end else if (count_now) begin
			if (repeat_mode) begin
				// Low for one count from the tick at one, reloaded on that same tick
				if (at_one) begin
					count_reg <= reload_reg; // RL16
					out_reg <= 1'b0; // RL16
				end else begin
					count_reg <= count_reg - 16'h0001;
					out_reg <= 1'b1;
				end
			end else if (!at_zero) begin
				count_reg <= count_reg - 16'h0001;
				out_reg <= at_one;
			end
		end
	end
endmodule
`default_nettype wire

/* rtl/dtdu_top.sv */
// Acquisition timing counters and output code update logic
`timescale 1ns/1ns
`default_nettype none
`include "dtdu_cfg.svh"
module dtdu_top (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Host write port
	input wire logic host_wr,
	input wire dtdu_pkg::dtdu_addr_t host_addr,
	input wire dtdu_pkg::dtdu_count_t host_wdata,
	// Control levels and pulses
	input wire logic deferred_output_update_bit,
	input wire logic acq_clk_from_gen0,
	input wire logic interval_scan_mode,
	input wire logic single_interval_mode,
	input wire logic controlled_mode,
	input wire logic dac0_bipolar,
	input wire logic dac1_bipolar,
	input wire logic acq_start,
	input wire logic acq_stop,
	// Connector
	input wire logic gen_clk1,
	input wire logic gen_clk2,
	input wire logic [2:0] gen_gate,
	input wire logic external_output_update_n,
	output logic [2:0] acq_out,
	output logic [2:0] gen_out,
	output logic scan_start,
	output logic acq_running,
	// Output codes as levels, zero is lowest
	output dtdu_pkg::dtdu_code_t dac0_level,
	output dtdu_pkg::dtdu_code_t dac1_level
);
	import dtdu_pkg::*;

	function automatic logic fell(input logic prev, input logic cur);
		fell = prev && !cur;
	endfunction

	function automatic dtdu_code_t to_level(input dtdu_code_t code, input logic bipolar);
		to_level = bipolar ? (code ^ `DTDU_BIPOLAR_FLIP) : code; // RL4
	endfunction

	// Timebases
	logic [3:0] osc_div_reg;
	logic [3:0] tba_div_reg;
	logic [5:0] tbb0_div_reg;
	logic clk_ext1_prev_reg;
	logic clk_ext2_prev_reg;
	wire osc_tick = (osc_div_reg == 4'(`DTDU_OSC_DIV - 1));
	wire tick_1m = osc_tick && (tba_div_reg == 4'(`DTDU_TBA_DIV - 1));
	wire tick_2m = (tbb0_div_reg == 6'(`DTDU_TBB0_DIV - 1));

	always_ff @(posedge clk) begin
		if (srst) begin
			osc_div_reg <= 4'h0;
			tba_div_reg <= 4'h0;
			tbb0_div_reg <= 6'h00;
			clk_ext1_prev_reg <= 1'b0;
			clk_ext2_prev_reg <= 1'b0;
		end else begin
			osc_div_reg <= osc_tick ? 4'h0 : osc_div_reg + 4'h1;
			// 1 MHz from the 10 MHz oscillator tick
			if (osc_tick) begin
				tba_div_reg <= (tba_div_reg == 4'(`DTDU_TBA_DIV - 1)) ? 4'h0 : tba_div_reg + 4'h1; // RL7
			end
			tbb0_div_reg <= tick_2m ? 6'h00 : tbb0_div_reg + 6'h01; // RL8
			clk_ext1_prev_reg <= gen_clk1;
			clk_ext2_prev_reg <= gen_clk2;
		end
	end

	// Host write decode
	wire wr_mode_a = host_wr && (host_addr == `DTDU_ADDR_MODE_A);
	wire wr_mode_b = host_wr && (host_addr == `DTDU_ADDR_MODE_B);
	wire wr_d0_lo = host_wr && (host_addr == `DTDU_ADDR_DAC0_LO);
	wire wr_d0_hi = host_wr && (host_addr == `DTDU_ADDR_DAC0_HI);
	wire wr_d1_lo = host_wr && (host_addr == `DTDU_ADDR_DAC1_LO);
	wire wr_d1_hi = host_wr && (host_addr == `DTDU_ADDR_DAC1_HI);
	wire wr_interval = host_wr && (host_addr == `DTDU_ADDR_INTERVAL);

	dtdu_byte_t mode_a_reg;
	dtdu_byte_t mode_b_reg;
	dtdu_byte_t interval_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			mode_a_reg <= `DTDU_MODE_A_RST;
			mode_b_reg <= `DTDU_MODE_B_RST;
			interval_reg <= `DTDU_INTERVAL_RST;
		end else begin
			if (wr_mode_a) mode_a_reg <= host_wdata[7:0]; // RL5
			if (wr_mode_b) mode_b_reg <= host_wdata[7:0]; // RL5
			if (wr_interval) interval_reg <= host_wdata[7:0];
		end
	end

	// Six counters: 0..2 group A, 3..5 group B
	logic [5:0] c_tick;
	logic [5:0] c_gate;
	logic [5:0] c_out;
	logic [5:0] c_expired;
	logic [5:0] c_out_prev_reg;
	wire [5:0] c_fell = c_out_prev_reg & ~c_out;
	wire [5:0] c_repeat = {mode_b_reg[2:0], mode_a_reg[2:0]};
	dtdu_acq_e state_reg;
	dtdu_acq_e state_next;
	wire running = (state_reg == DTDU_RUN);

	// Group A clock, optionally from general counter 0 output
	wire clk_a = acq_clk_from_gen0 ? c_fell[3] : tick_1m; // RL7 RL9
	wire a0_gated_off = controlled_mode && c_expired[1]; // RL17

	assign c_tick[0] = clk_a;
	assign c_tick[1] = c_fell[0];
	assign c_tick[2] = clk_a;
	assign c_tick[3] = tick_2m; // RL8
	assign c_tick[4] = interval_scan_mode ? clk_a : (gen_clk1 && !clk_ext1_prev_reg); // RL10 RL12
	assign c_tick[5] = gen_clk2 && !clk_ext2_prev_reg; // RL12
	assign c_gate[0] = running && !a0_gated_off; // RL6 RL17
	assign c_gate[1] = running;
	assign c_gate[2] = 1'b1;
	assign c_gate[5:3] = gen_gate; // RL6

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : g_cnt
			dtdu_counter u_cnt (
				.clk(clk),
				.srst(srst),
				.tick(c_tick[gi]),
				.gate(c_gate[gi]),
				.repeat_mode(c_repeat[gi]),
				.load(host_wr && (host_addr == 4'(gi))), // RL15
				.load_value(host_wdata),
				.cnt_out(c_out[gi]),
				.expired(c_expired[gi])
			);
		end
	endgenerate

	assign acq_out = c_out[2:0];
	assign gen_out = c_out[5:3];

	// Acquisition sequencing
	dtdu_byte_t samples_reg;
	logic scan_start_reg;
	wire scan_evt = interval_scan_mode && c_fell[4]; // RL11
	wire sample_evt = running && c_fell[0];
	wire interval_full = single_interval_mode && sample_evt && ((samples_reg + 8'h01) == interval_reg);
	wire acq_done = acq_stop || (controlled_mode && c_expired[1]); // RL14

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			DTDU_IDLE: begin
				if (acq_start) state_next = DTDU_RUN;
			end
			DTDU_RUN: begin
				if (acq_done) state_next = DTDU_IDLE; // RL14
				else if (interval_full) state_next = DTDU_PAUSE; // RL13
			end
			DTDU_PAUSE: begin
				if (acq_done) state_next = DTDU_IDLE;
				else if (scan_evt) state_next = DTDU_RUN; // RL13
			end
			default: state_next = DTDU_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= DTDU_IDLE;
			samples_reg <= 8'h00;
			scan_start_reg <= 1'b0;
			c_out_prev_reg <= 6'h3F;
		end else begin
			state_reg <= state_next;
			c_out_prev_reg <= c_out;
			scan_start_reg <= scan_evt && (state_reg != DTDU_IDLE); // RL11
			if (state_next != DTDU_RUN) samples_reg <= 8'h00;
			else if (sample_evt) samples_reg <= samples_reg + 8'h01; // RL13
		end
	end

	assign scan_start = scan_start_reg;

	logic acq_running_reg;
	always_ff @(posedge clk) begin
		if (srst) acq_running_reg <= 1'b0;
		else acq_running_reg <= (state_next == DTDU_RUN);
	end
	assign acq_running = acq_running_reg;

	// External update synchroniser
	logic upd_s1_reg;
	logic upd_s2_reg;
	logic upd_s3_reg;
	always_ff @(posedge clk) begin
		if (srst) begin
			upd_s1_reg <= 1'b1;
			upd_s2_reg <= 1'b1;
			upd_s3_reg <= 1'b1;
		end else begin
			upd_s1_reg <= external_output_update_n; // RL18
			upd_s2_reg <= upd_s1_reg;
			upd_s3_reg <= upd_s2_reg;
		end
	end
	wire upd_evt = fell(upd_s3_reg, upd_s2_reg) || fell(c_out_prev_reg[2], c_out[2]); // RL3 RL18

	// Output codes
	dtdu_code_t code0_reg;
	dtdu_code_t code1_reg;
	dtdu_code_t level0_reg;
	dtdu_code_t level1_reg;
	wire dtdu_code_t code0_next = wr_d0_hi ? {host_wdata[`DTDU_HI_NIBBLE_W-1:0], code0_reg[7:0]} :
		wr_d0_lo ? {code0_reg[11:8], host_wdata[7:0]} : code0_reg; // RL1
	wire dtdu_code_t code1_next = wr_d1_hi ? {host_wdata[`DTDU_HI_NIBBLE_W-1:0], code1_reg[7:0]} :
		wr_d1_lo ? {code1_reg[11:8], host_wdata[7:0]} : code1_reg; // RL1
	wire apply0 = deferred_output_update_bit ? upd_evt : (wr_d0_lo || wr_d0_hi); // RL2 RL3
	wire apply1 = deferred_output_update_bit ? upd_evt : (wr_d1_lo || wr_d1_hi); // RL2 RL3

	always_ff @(posedge clk) begin
		if (srst) begin
			code0_reg <= `DTDU_CODE_RST;
			code1_reg <= `DTDU_CODE_RST;
			level0_reg <= `DTDU_CODE_RST;
			level1_reg <= `DTDU_CODE_RST;
		end else begin
			code0_reg <= code0_next;
			code1_reg <= code1_next;
			if (apply0) level0_reg <= to_level(code0_next, dac0_bipolar); // RL2 RL4
			if (apply1) level1_reg <= to_level(code1_next, dac1_bipolar); // RL2 RL4
		end
	end

	assign dac0_level = level0_reg;
	assign dac1_level = level1_reg;
endmodule
`default_nettype wire

/* tb/dtdu_chk.sv */
// Port checker for the timing and output update block
`timescale 1ns/1ns
`default_nettype none
`include "dtdu_cfg.svh"
module dtdu_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Host and control
	input wire logic host_wr,
	input wire dtdu_pkg::dtdu_addr_t host_addr,
	input wire dtdu_pkg::dtdu_count_t host_wdata,
	input wire logic deferred_output_update_bit,
	input wire logic interval_scan_mode,
	input wire logic single_interval_mode,
	input wire logic controlled_mode,
	input wire logic dac0_bipolar,
	input wire logic acq_start,
	input wire logic acq_stop,
	// Connector and levels
	input wire logic external_output_update_n,
	input wire logic [2:0] acq_out,
	input wire logic [2:0] gen_out,
	input wire logic scan_start,
	input wire logic acq_running,
	input wire dtdu_pkg::dtdu_code_t dac0_level,
	input wire dtdu_pkg::dtdu_code_t dac1_level
);
	import dtdu_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	sequence quiet_s;
		(deferred_output_update_bit && external_output_update_n && !$fell(acq_out[2])) [*6];
	endsequence
	sequence idle_s;
		(!acq_running && !host_wr) [*3];
	endsequence
	reset_vals_a: assert property (disable iff (1'b0)
		srst |=> acq_out == 3'b111 && gen_out == 3'b111 && !acq_running && !scan_start && dac0_level == 12'h000)
		else $error("Outputs not at reset values");
	dac_hi_now_a: assert property (host_wr && !deferred_output_update_bit && host_addr == `DTDU_ADDR_DAC0_HI
		|=> dac0_level[11:8] == ($past(host_wdata[3:0]) ^ {$past(dac0_bipolar), 3'b000}))
		else $error("Channel 0 high byte not applied");
	dac_lo_now_a: assert property (host_wr && !deferred_output_update_bit && host_addr == `DTDU_ADDR_DAC1_LO
		|=> dac1_level[7:0] == $past(host_wdata[7:0])) else $error("Channel 1 low byte not applied");
	defer_hold_a: assert property (quiet_s |=> $stable(dac0_level) && $stable(dac1_level))
		else $error("Level moved without update event");
	scan_start_a: assert property (interval_scan_mode && $fell(gen_out[1]) |-> ##[0:3] scan_start)
		else $error("No scan start after interval pulse");
	ctl_end_a: assert property (controlled_mode && $rose(acq_out[1]) |-> ##[0:2] !acq_running)
		else $error("Acquisition not ended at sample count zero");
	gate_off_a: assert property (idle_s |-> $stable(acq_out[0]))
		else $error("Interval counter moved while gated off");
	start_run_a: assert property (acq_start && !acq_stop && !controlled_mode && !single_interval_mode
		|-> ##[1:2] acq_running) else $error("Acquisition did not start");
	run_hold_a: assert property (acq_running && !acq_stop && !controlled_mode && !single_interval_mode
		|=> acq_running) else $error("Free-run acquisition ended by itself");
endmodule
bind dtdu_top dtdu_chk i_chk (.clk(clk), .srst(srst), .host_wr(host_wr), .host_addr(host_addr),
	.host_wdata(host_wdata), .deferred_output_update_bit(deferred_output_update_bit),
	.interval_scan_mode(interval_scan_mode), .single_interval_mode(single_interval_mode),
	.controlled_mode(controlled_mode), .dac0_bipolar(dac0_bipolar), .acq_start(acq_start), .acq_stop(acq_stop),
	.external_output_update_n(external_output_update_n), .acq_out(acq_out), .gen_out(gen_out),
	.scan_start(scan_start), .acq_running(acq_running), .dac0_level(dac0_level), .dac1_level(dac1_level));
`default_nettype wire

/* tb/dtdu_partner.sv */
// Connector side model: counter timebases and update pin
`timescale 1ns/1ns
`default_nettype none
module dtdu_partner (
	// Board clock
	input wire logic clk,
	// Connector
	output logic gen_clk1,
	output logic gen_clk2,
	output logic external_output_update_n
);
	int n;
	initial begin
		n = 0;
		gen_clk1 = 1'b0;
		gen_clk2 = 1'b0;
		external_output_update_n = 1'b1;
	end
	// Periods of 20 and 30 board cycles
	always @(negedge clk) begin
		n <= n + 1;
		if (n % 10 == 9) gen_clk1 <= ~gen_clk1;
		if (n % 15 == 14) gen_clk2 <= ~gen_clk2;
	end
	task automatic pulse_update();
		@(negedge clk);
		external_output_update_n <= 1'b0;
		repeat (4) @(negedge clk);
		external_output_update_n <= 1'b1;
	endtask
endmodule
`default_nettype wire

/* tb/tb_daq_timing_and_dac_update.sv */
// Self-checking bench for the timing and output update block
`timescale 1ns/1ns
`default_nettype none
`include "dtdu_cfg.svh"
module tb_daq_timing_and_dac_update;
	import dtdu_pkg::*;
	logic clk, srst, host_wr, deferred_output_update_bit, acq_clk_from_gen0, interval_scan_mode;
	logic controlled_mode, acq_start, acq_stop, gen_clk1, gen_clk2, external_output_update_n;
	logic scan_start, acq_running, single_interval_mode;
	logic [2:0] acq_out, gen_out, gen_gate;
	wire logic [5:0] outs;
	dtdu_addr_t host_addr;
	dtdu_count_t host_wdata;
	dtdu_code_t dac0_level, dac1_level;
	int fail_count, tests_run;
	assign outs = {gen_out, acq_out};
	dtdu_top i_dut (.clk(clk), .srst(srst), .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
		.deferred_output_update_bit(deferred_output_update_bit), .acq_clk_from_gen0(acq_clk_from_gen0),
		.interval_scan_mode(interval_scan_mode), .single_interval_mode(single_interval_mode),
		.controlled_mode(controlled_mode),
		.dac0_bipolar(1'b1), .dac1_bipolar(1'b0), .acq_start(acq_start), .acq_stop(acq_stop),
		.gen_clk1(gen_clk1), .gen_clk2(gen_clk2), .gen_gate(gen_gate),
		.external_output_update_n(external_output_update_n), .acq_out(acq_out), .gen_out(gen_out),
		.scan_start(scan_start), .acq_running(acq_running), .dac0_level(dac0_level), .dac1_level(dac1_level));
	dtdu_partner i_far (.clk(clk), .gen_clk1(gen_clk1), .gen_clk2(gen_clk2),
		.external_output_update_n(external_output_update_n));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic report_and_stop();
		if (fail_count == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask
	task automatic wr(input dtdu_addr_t a, input dtdu_count_t d);
		@(negedge clk);
		host_wr = 1'b1;
		host_addr = a;
		host_wdata = d;
		@(negedge clk);
		host_wr = 1'b0;
		@(negedge clk);
	endtask
	task automatic strobe(input bit stop);
		@(negedge clk);
		if (stop) acq_stop = 1'b1;
		else acq_start = 1'b1;
		@(negedge clk);
		acq_start = 1'b0;
		acq_stop = 1'b0;
	endtask
	task automatic wait_fall(input int s);
		logic p;
		p = outs[s];
		for (int i = 0; i < 2500; i++) begin
			@(negedge clk);
			if (p && !outs[s]) break;
			p = outs[s];
		end
	endtask
	// Cycles between second and third fall of one output
	task automatic meas(input int s, input int exp);
		time t0;
		wait_fall(s);
		wait_fall(s);
		t0 = $time;
		wait_fall(s);
		chk(16'(($time - t0) / 10), 16'(exp));
	endtask
	// Falls of one output over n cycles
	task automatic falls(input int s, input int n, output int k);
		logic p;
		k = 0;
		p = outs[s];
		repeat (n) begin
			@(negedge clk);
			if (p && !outs[s]) k++;
			p = outs[s];
		end
	endtask
	task automatic t_reset();
		chk({10'h000, acq_out, gen_out}, 16'h003F);
		chk({4'h0, dac0_level}, 16'h0000);
	endtask
	task automatic t_imm();
		wr(`DTDU_ADDR_DAC0_HI, 16'h0008);
		chk({4'h0, dac0_level}, 16'h0000);
		wr(`DTDU_ADDR_DAC0_LO, 16'h00FF);
		chk({4'h0, dac0_level}, 16'h00FF);
		wr(`DTDU_ADDR_DAC1_LO, 16'h0034);
		wr(`DTDU_ADDR_DAC1_HI, 16'h0002);
		chk({4'h0, dac1_level}, 16'h0234);
	endtask
	task automatic t_defer();
		deferred_output_update_bit = 1'b1;
		wr(`DTDU_ADDR_DAC0_LO, 16'h0011);
		chk({4'h0, dac0_level}, 16'h00FF);
		i_far.pulse_update();
		repeat (8) @(negedge clk);
		chk({4'h0, dac0_level}, 16'h0011);
		wr(`DTDU_ADDR_DAC1_HI, 16'h0005);
		chk({4'h0, dac1_level}, 16'h0234);
		wr(`DTDU_ADDR_ACQ2, 16'h0002);
		repeat (350) @(negedge clk);
		chk({4'h0, dac1_level}, 16'h0534);
		deferred_output_update_bit = 1'b0;
	endtask
	task automatic t_periods();
		wr(`DTDU_ADDR_MODE_B, 16'h0003);
		wr(`DTDU_ADDR_GEN0, 16'h0004);
		wr(`DTDU_ADDR_GEN1, 16'h0005);
		meas(3, 200);
		meas(4, 100);
		wr(`DTDU_ADDR_ACQ0, 16'h0003);
		strobe(1'b0);
		meas(0, 300);
		acq_clk_from_gen0 = 1'b1;
		meas(0, 600);
		acq_clk_from_gen0 = 1'b0;
		interval_scan_mode = 1'b1;
		meas(4, 500);
		interval_scan_mode = 1'b0;
	endtask
	task automatic t_ctl();
		strobe(1'b1);
		wr(`DTDU_ADDR_ACQ1, 16'h0002);
		wr(`DTDU_ADDR_ACQ0, 16'h0003);
		controlled_mode = 1'b1;
		strobe(1'b0);
		repeat (350) @(negedge clk);
		chk(16'(acq_running), 16'h0001);
		repeat (650) @(negedge clk);
		chk({15'h0000, acq_running}, 16'h0000);
		chk({15'h0000, acq_out[1]}, 16'h0001);
	endtask
	// Two samples per interval, resumed by the interval counter, then gate test
	task automatic t_interval();
		int k;
		controlled_mode = 1'b0;
		wr(`DTDU_ADDR_GEN1, 16'h0014);
		interval_scan_mode = 1'b1;
		single_interval_mode = 1'b1;
		wr(`DTDU_ADDR_INTERVAL, 16'h0002);
		wr(`DTDU_ADDR_ACQ0, 16'h0003);
		strobe(1'b0);
		falls(0, 1000, k);
		chk(16'(k), 16'h0002);
		chk({15'h0000, acq_running}, 16'h0000);
		k = 0;
		for (int i = 0; i < 2500 && k == 0; i++) begin
			@(negedge clk);
			if (scan_start === 1'b1) k = 1;
		end
		chk(16'(k), 16'h0001);
		chk({15'h0000, acq_running}, 16'h0001);
		@(negedge clk);
		chk({15'h0000, scan_start}, 16'h0000);
		interval_scan_mode = 1'b0;
		single_interval_mode = 1'b0;
		strobe(1'b1);
		gen_gate = 3'b110;
		falls(3, 400, k);
		chk(16'(k), 16'h0000);
		gen_gate = 3'b111;
		falls(3, 400, k);
		chk(16'(k != 0), 16'h0001);
	endtask
	initial begin
		{srst, host_wr, host_addr, host_wdata} = {1'b1, 21'h000000};
		{deferred_output_update_bit, acq_clk_from_gen0, interval_scan_mode} = 3'b000;
		{controlled_mode, acq_start, acq_stop, single_interval_mode, gen_gate} = 7'h07;
		fail_count = 0;
		tests_run = 0;
		repeat (5) @(negedge clk);
		srst = 1'b0;
		t_reset();
		t_imm();
		t_defer();
		t_periods();
		t_ctl();
		t_interval();
		report_and_stop();
	end
	initial begin
		#600000;
		fail_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire
